/* File: hdl/hsc_pkg.sv */
// constants for the counter status and general parameter word map
// assumes one 10 MHz clock and a plain word-addressed register port
package hsc_pkg;
   localparam int ADDR_W = 9;
   localparam logic [8:0] PARAM_WORDS   = 9'h190; // 400 words
   localparam logic [8:0] GENERAL_WORDS = 9'h01E; // 30 words
   localparam logic [8:0] COUNTER_WORDS = 9'h02D; // 45 words
   // general parameter word offsets
   localparam logic [8:0] OFS_MODE     = 9'h000;
   localparam logic [8:0] OFS_OTASK    = 9'h001;
   localparam logic [8:0] OFS_OMASK_LO = 9'h002;
   localparam logic [8:0] OFS_OMASK_HI = 9'h003;
   localparam logic [8:0] OFS_ITASK    = 9'h004;
   localparam logic [8:0] OFS_IMASK    = 9'h005;
   localparam logic [8:0] OFS_DRV      = 9'h006;
   localparam logic [8:0] OFS_CFILT    = 9'h007;
   localparam logic [8:0] OFS_IFILT    = 9'h008;
   localparam logic [8:0] OFS_DLY0     = 9'h009;
   localparam logic [8:0] OFS_DUR0     = 9'h00A;
   localparam logic [8:0] OFS_DLY1     = 9'h00B;
   localparam logic [8:0] OFS_DUR1     = 9'h00C;
   localparam logic [8:0] OFS_PAT_LO   = 9'h015;
   localparam logic [8:0] OFS_PAT_HI   = 9'h016;
   // counter 2 status words, placed above the parameter area
   localparam logic [8:0] OFS_ACT_LO   = 9'h1A0;
   localparam logic [8:0] OFS_ACT_HI   = 9'h1A1;
   localparam logic [8:0] OFS_CNT_LO   = 9'h1A2;
   localparam logic [8:0] OFS_CNT_HI   = 9'h1A3;
   localparam logic [8:0] OFS_STAT     = 9'h1A4;
   localparam logic [8:0] OFS_CTRL     = 9'h1A5;
   // status bit positions
   localparam int B_OVF = 0;
   localparam int B_UNF = 1;
   localparam int B_RUN = 2;
   localparam int B_DIR = 3;
   localparam int B_PRE = 4;
   localparam int B_RST = 5;
   localparam int B_CAP = 6;
   localparam int B_IDX = 7;
   localparam int B_RR0 = 10;
   localparam int B_RR1 = 11;
   localparam int B_SIM = 15;
   // field codes and limits
   localparam logic [7:0]  MODE_RANGE   = 8'h00;
   localparam logic [7:0]  MODE_COMPARE = 8'h01;
   localparam logic [7:0]  COMB_AND     = 8'h01;
   localparam logic [7:0]  COMB_OR      = 8'h00;
   localparam logic [15:0] OTASK_MAX    = 16'h0192;
   localparam logic [15:0] ITASK_MAX    = 16'h0252;
   localparam logic [15:0] BCD_MS_MAX   = 16'h9999;
   localparam logic [3:0]  FLT_CONTINUE = 4'h0;
   localparam logic [3:0]  FLT_FREEZE   = 4'h1;
   localparam logic [3:0]  FLT_PREDEF   = 4'h2;
   localparam logic [7:0]  CF_50K  = 8'h00;
   localparam logic [7:0]  CF_500K = 8'h01;
   localparam logic [7:0]  CF_10K  = 8'h02;
   localparam logic [7:0]  IF_50K  = 8'h00;
   localparam logic [7:0]  IF_10K  = 8'h01;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [31:0] RST_DWORD = 32'h0000_0000;
   // timing: one millisecond in clock cycles
   localparam int CLK_HZ = 10000000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam logic [13:0] MS_TICK_LAST = 14'(MS_CYCLES - 1);
   typedef enum logic [1:0] {
      PS_IDLE  = 2'b00,
      PS_DELAY = 2'b01,
      PS_ON    = 2'b11
   } hsc_pulse_state_t;
   // bcd word to binary, for 0..9999
   function automatic logic [13:0] hsc_bcd2bin(input logic [15:0] b);
      logic [13:0] r;
      // 14-bit terms, or the thousands product wraps above 1023
      r = b[15:12] * 14'd1000 + b[11:8] * 14'd100 + b[7:4] * 14'd10;
      return 14'(r + b[3:0]);
   endfunction
endpackage

/* File: hdl/hsc_pulse_if.sv */
// carrier between the register bank and the pulse timers
// assumes both ends on i_sys_clk
`timescale 1ns/1ns
`default_nettype none
interface hsc_pulse_if;
   logic        trig;   // request from the pattern logic
   logic [15:0] delay;  // bcd ms
   logic [15:0] dur;    // bcd ms, zero = endless
   logic        ms_tick;
   logic        out;
   modport bank  (output trig, delay, dur, ms_tick, input out);
   modport timer (input trig, delay, dur, ms_tick, output out);
endinterface
`default_nettype wire

/* File: hdl/hsc_pulse.sv */
// one digital output with turn-on delay and pulse duration
// assumes a millisecond tick from the bank and bcd settings
`timescale 1ns/1ns
`default_nettype none
module hsc_pulse
   import hsc_pkg::*;
(
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst_n,
   hsc_pulse_if.timer p
);
   hsc_pulse_state_t state_reg;
   logic [13:0]      ms_reg;
   logic [13:0]      dly_bin;
   logic [13:0]      dur_bin;
   logic             out_reg;
   assign dly_bin = hsc_bcd2bin(p.delay);
   assign dur_bin = hsc_bcd2bin(p.dur);
   assign p.out   = out_reg;
   // delay then on; a zero duration keeps it on until trigger drops
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg <= PS_IDLE;
         ms_reg    <= 14'h0000;
         out_reg   <= 1'b0;
      end else begin
         case (state_reg)
            PS_IDLE: begin
               ms_reg  <= 14'h0000;
               out_reg <= 1'b0;
               if (p.trig) begin
                  state_reg <= PS_DELAY;
               end
            end
            PS_DELAY: begin
               if (!p.trig) begin
                  state_reg <= PS_IDLE;
               end else if (ms_reg >= dly_bin) begin
                  state_reg <= PS_ON;
                  ms_reg    <= 14'h0000;
                  out_reg   <= 1'b1;
               end else if (p.ms_tick) begin
                  ms_reg <= ms_reg + 14'h0001;
               end
            end
            PS_ON: begin
               // duration zero never ends the pulse
               if (dur_bin != 14'h0000 && ms_reg >= dur_bin) begin
                  out_reg <= 1'b0;
               end else if (p.ms_tick) begin
                  ms_reg <= ms_reg + 14'h0001;
               end
               if (!p.trig) begin
                  state_reg <= PS_IDLE;
                  out_reg   <= 1'b0;
               end
            end
            default: begin
               state_reg <= PS_IDLE;
            end
         endcase
      end
   end
   chk_zero_endless: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      (state_reg == PS_ON && p.trig && dur_bin == 14'h0000 && out_reg)
         |=> out_reg)
      else $error("zero duration pulse ended");
endmodule // hsc_pulse
`default_nettype wire

/* File: hdl/hsc_bank.sv */
// counter 2 status words and general parameter words
// assumes a counter core driving the status inputs, one cycle strobes
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module hsc_bank
   import hsc_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [8:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [15:0]      o_rdata,
   input  wire logic        i_io_refresh,   // controller cycle boundary
   input  wire logic        i_linear,
   input  wire logic        i_simple,
   input  wire logic        i_at_upper,
   input  wire logic        i_at_lower,
   input  wire logic        i_count_up,
   input  wire logic [31:0] i_count_value,
   input  wire logic        i_ev_preset,
   input  wire logic        i_ev_reset,
   input  wire logic        i_ev_capture,
   input  wire logic        i_ev_index,
   input  wire logic [1:0]  i_rate_range,
   input  wire logic [31:0] i_range_active,
   input  wire logic [31:0] i_pattern_c1,
   input  wire logic [31:0] i_pattern_c2,
   input  wire logic        i_fault,        // mode change or bus/ovf error
   output logic             o_gate_open,
   output logic             o_compare_mode,
   output logic [1:0]       o_driver_source,
   output logic [7:0]       o_cnt_filter,
   output logic [7:0]       o_in_filter,
   output logic [7:0]       o_otask_offset,
   output logic [7:0]       o_itask_offset,
   output logic [31:0]      o_oirq_mask,
   output logic [1:0]       o_iirq_mask,
   output logic [31:0]      o_outputs,
   output logic [1:0]       o_dout
);
   logic [15:0] mode_reg, otask_reg, itask_reg, imask_reg, drv_reg;
   logic [15:0] cfilt_reg, ifilt_reg;
   logic [31:0] omask_reg, pat_reg, out_reg;
   logic [15:0] dly_reg [2];
   logic [15:0] dur_reg [2];
   logic [15:0] stat_reg;
   logic [31:0] act_reg, cnt_reg;
   logic [3:0]  ev_pend_reg;
   logic        gate_reg;
   logic [13:0] tick_reg;
   logic        tick;
   logic [31:0] out_next;
   logic [3:0]  ev_in;
   hsc_pulse_if pif [2] ();

   assign ev_in = {i_ev_index, i_ev_capture, i_ev_reset, i_ev_preset};

   // word write decode, used for every writable word
   function automatic logic hit(input logic [8:0] a, input logic [8:0] o);
      return a == o;
   endfunction

   // general words; reserved and unused bits are simply not stored
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         mode_reg  <= RST_WORD; // range mode, or-combine
         otask_reg <= RST_WORD;
         itask_reg <= RST_WORD;
         omask_reg <= RST_DWORD;
         imask_reg <= RST_WORD;
         drv_reg   <= RST_WORD;
         cfilt_reg <= RST_WORD; // 50 kHz
         ifilt_reg <= RST_WORD; // 50 kHz
         pat_reg   <= RST_DWORD;
      end else if (i_wr) begin
         if (hit(i_addr, OFS_MODE)) mode_reg <= i_wdata;
         // out of range bcd offsets are refused
         if (hit(i_addr, OFS_OTASK) && i_wdata <= OTASK_MAX)
            otask_reg <= i_wdata;
         if (hit(i_addr, OFS_ITASK) && i_wdata <= ITASK_MAX)
            itask_reg <= i_wdata;
         if (hit(i_addr, OFS_OMASK_LO)) omask_reg[15:0] <= i_wdata;
         if (hit(i_addr, OFS_OMASK_HI)) omask_reg[31:16] <= i_wdata;
         if (hit(i_addr, OFS_IMASK)) imask_reg <= {14'h0000, i_wdata[1:0]};
         // only driver bits and fault field kept
         if (hit(i_addr, OFS_DRV))
            drv_reg <= {i_wdata[15:12], 10'h000, i_wdata[1:0]};
         if (hit(i_addr, OFS_CFILT)) cfilt_reg <= {8'h00, i_wdata[7:0]};
         if (hit(i_addr, OFS_IFILT)) ifilt_reg <= {8'h00, i_wdata[7:0]};
         if (hit(i_addr, OFS_PAT_LO)) pat_reg[15:0] <= i_wdata;
         if (hit(i_addr, OFS_PAT_HI)) pat_reg[31:16] <= i_wdata;
      end
   end

   // pulse timing words, one pair per digital output
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_out
         logic [8:0] dly_ofs, dur_ofs;
         assign dly_ofs = (g == 0) ? OFS_DLY0 : OFS_DLY1;
         assign dur_ofs = (g == 0) ? OFS_DUR0 : OFS_DUR1;
         always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               dly_reg[g] <= RST_WORD;
               dur_reg[g] <= RST_WORD;
            end else if (i_wr && i_wdata <= BCD_MS_MAX) begin
               if (hit(i_addr, dly_ofs)) dly_reg[g] <= i_wdata;
               if (hit(i_addr, dur_ofs)) dur_reg[g] <= i_wdata;
            end
         end
         assign pif[g].trig    = out_reg[g];
         assign pif[g].delay   = dly_reg[g];
         assign pif[g].dur     = dur_reg[g];
         assign pif[g].ms_tick = tick;
         hsc_pulse u_pulse (
            .i_sys_clk (i_sys_clk),
            .i_rst_n   (i_rst_n),
            .p         (pif[g])
         );
         assign o_dout[g] = pif[g].out;
      end
   endgenerate

   // millisecond tick for the pulse timers
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) tick_reg <= 14'h0000;
      else if (tick_reg == MS_TICK_LAST) tick_reg <= 14'h0000;
      else tick_reg <= tick_reg + 14'h0001;
   end
   assign tick = (tick_reg == MS_TICK_LAST);

   // gate stays closed after reset until control word bit 0 set
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) gate_reg <= 1'b0;
      else if (i_wr && hit(i_addr, OFS_CTRL)) gate_reg <= i_wdata[0];
   end

   // events caught between refreshes; one seen in the refresh cycle goes
   // straight into the snapshot, so keeping it would show it twice
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) ev_pend_reg <= 4'h0;
      else if (i_io_refresh) ev_pend_reg <= 4'h0;
      else ev_pend_reg <= ev_pend_reg | ev_in;
   end

   // status snapshot taken once per controller cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         stat_reg <= RST_WORD;
         act_reg  <= RST_DWORD;
         cnt_reg  <= RST_DWORD;
      end else if (i_io_refresh) begin
         stat_reg <= RST_WORD; // unused bits stay zero
         stat_reg[B_OVF] <= i_linear && i_at_upper;
         stat_reg[B_UNF] <= i_linear && i_at_lower;
         stat_reg[B_RUN] <= gate_reg;
         stat_reg[B_DIR] <= i_count_up;
         // pending events shown for exactly one controller cycle
         stat_reg[B_IDX:B_PRE] <= ev_pend_reg | ev_in;
         // rate and range bits meaningless for simple counters
         stat_reg[B_RR0] <= !i_simple && i_rate_range[0];
         stat_reg[B_RR1] <= !i_simple && i_rate_range[1];
         stat_reg[B_SIM] <= i_simple;
         act_reg <= i_simple ? RST_DWORD : i_range_active;
         cnt_reg <= i_count_value;
      end
   end

   // output pattern: mode, combine, then fault handling
   always_comb begin
      if (mode_reg[7:0] == MODE_RANGE && mode_reg[15:8] == COMB_AND)
         out_next = i_pattern_c1 & i_pattern_c2;
      else
         out_next = i_pattern_c1 | i_pattern_c2;
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) out_reg <= RST_DWORD;
      else if (!i_fault || drv_reg[15:12] == FLT_CONTINUE)
         out_reg <= out_next;
      else if (drv_reg[15:12] == FLT_PREDEF)
         out_reg <= pat_reg;
      // freeze: hold value
   end

   // read port, data valid the cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) o_rdata <= RST_WORD;
      else if (i_rd) begin
         case (i_addr)
            OFS_MODE:     o_rdata <= mode_reg;
            OFS_OTASK:    o_rdata <= otask_reg;
            OFS_OMASK_LO: o_rdata <= omask_reg[15:0];
            OFS_OMASK_HI: o_rdata <= omask_reg[31:16];
            OFS_ITASK:    o_rdata <= itask_reg;
            OFS_IMASK:    o_rdata <= imask_reg;
            OFS_DRV:      o_rdata <= drv_reg;
            OFS_CFILT:    o_rdata <= cfilt_reg;
            OFS_IFILT:    o_rdata <= ifilt_reg;
            OFS_DLY0:     o_rdata <= dly_reg[0];
            OFS_DUR0:     o_rdata <= dur_reg[0];
            OFS_DLY1:     o_rdata <= dly_reg[1];
            OFS_DUR1:     o_rdata <= dur_reg[1];
            OFS_PAT_LO:   o_rdata <= pat_reg[15:0];
            OFS_PAT_HI:   o_rdata <= pat_reg[31:16];
            OFS_ACT_LO:   o_rdata <= act_reg[15:0];
            OFS_ACT_HI:   o_rdata <= act_reg[31:16];
            OFS_CNT_LO:   o_rdata <= cnt_reg[15:0];
            OFS_CNT_HI:   o_rdata <= cnt_reg[31:16];
            OFS_STAT:     o_rdata <= stat_reg;
            OFS_CTRL:     o_rdata <= {15'h0000, gate_reg};
            default:      o_rdata <= RST_WORD; // zero
         endcase
      end else o_rdata <= RST_WORD;
   end

   // decoded settings to the counter core
   assign o_gate_open     = gate_reg;
   assign o_compare_mode  = mode_reg[7:0] == MODE_COMPARE;
   assign o_driver_source = drv_reg[1:0];
   assign o_cnt_filter    = cfilt_reg[7:0];
   assign o_in_filter     = ifilt_reg[7:0];
   // offsets kept in bcd, handed on in binary so 192 and 252 fit 8 bits
   assign o_otask_offset  = 8'(hsc_bcd2bin(otask_reg));
   assign o_itask_offset  = 8'(hsc_bcd2bin(itask_reg));
   assign o_oirq_mask     = omask_reg;
   assign o_iirq_mask     = imask_reg[1:0];
   assign o_outputs       = out_reg;

   // assertions, each beside nothing but the words it guards
   sequence s_refresh_event;
      i_io_refresh && (ev_pend_reg[0] || i_ev_preset);
   endsequence

   sequence s_refresh_quiet;
      i_io_refresh && ev_pend_reg == 4'h0 && ev_in == 4'h0;
   endsequence

   sequence s_range_and;
      (!i_fault || drv_reg[15:12] == FLT_CONTINUE)
         && mode_reg == {COMB_AND, MODE_RANGE};
   endsequence

   sequence s_fault_freeze;
      i_fault && drv_reg[15:12] == FLT_FREEZE;
   endsequence

   sequence s_fault_predef;
      i_fault && drv_reg[15:12] == FLT_PREDEF;
   endsequence

   // the refresh hands pending events to the snapshot and forgets them,
   // otherwise one event would show for two controller cycles
   chk_event_one_cycle: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh |=> ev_pend_reg == 4'h0)
      else $error("event kept past its refresh");

   chk_event_shown: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      s_refresh_event |=> stat_reg[B_PRE])
      else $error("event not shown after refresh");

   chk_event_quiet: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      s_refresh_quiet |=> stat_reg[B_IDX:B_PRE] == 4'h0)
      else $error("stale event shown");

   chk_overflow_bit: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh |=> stat_reg[B_OVF] == $past(i_linear && i_at_upper))
      else $error("overflow bit wrong");

   chk_underflow_bit: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh |=> stat_reg[B_UNF] == $past(i_linear && i_at_lower))
      else $error("underflow bit wrong");

   chk_gate_running: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh |=> stat_reg[B_RUN] == $past(gate_reg))
      else $error("gate bit wrong");

   chk_dir_bit: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh |=> stat_reg[B_DIR] == $past(i_count_up))
      else $error("direction bit wrong");

   chk_rate_bits: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh && !i_simple
         |=> stat_reg[B_RR1:B_RR0] == $past(i_rate_range))
      else $error("rate bits wrong");

   chk_simple_quiet: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh && i_simple |=> stat_reg[B_SIM] && act_reg == RST_DWORD
         && !stat_reg[B_RR0] && !stat_reg[B_RR1])
      else $error("simple counter shows ranges");

   chk_range_word: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      i_io_refresh && !i_simple |=> act_reg == $past(i_range_active))
      else $error("range activity word wrong");

   chk_unused_zero: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      stat_reg[9:8] == 2'b00 && stat_reg[14:12] == 3'b000)
      else $error("unused status bits set");

   chk_driver_unused: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      drv_reg[11:2] == 10'h000 && imask_reg[15:2] == 14'h0000
         && cfilt_reg[15:8] == 8'h00 && ifilt_reg[15:8] == 8'h00)
      else $error("unused parameter bits stored");

   chk_rdata_idle: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      !i_rd |=> o_rdata == RST_WORD)
      else $error("read data without a read");

   chk_combine_and: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      s_range_and |=> out_reg == $past(i_pattern_c1 & i_pattern_c2))
      else $error("and-combined pattern wrong");

   chk_freeze_hold: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      s_fault_freeze |=> $stable(out_reg))
      else $error("outputs moved while frozen");

   chk_predef_applied: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      s_fault_predef |=> out_reg == $past(pat_reg))
      else $error("predefined pattern not applied");

   chk_otask_range: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      otask_reg <= OTASK_MAX)
      else $error("output task offset out of range");

   chk_itask_range: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      itask_reg <= ITASK_MAX)
      else $error("input task offset out of range");

   chk_time_range: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      dly_reg[0] <= BCD_MS_MAX && dur_reg[0] <= BCD_MS_MAX
         && dly_reg[1] <= BCD_MS_MAX && dur_reg[1] <= BCD_MS_MAX)
      else $error("pulse time out of range");

   chk_tick_period: assert property (@(posedge i_sys_clk)
      disable iff (!i_rst_n)
      tick_reg <= MS_TICK_LAST)
      else $error("millisecond counter overran");
endmodule // hsc_bank
`default_nettype wire

/* File: testbench/hsc_core_model.sv */
// counter core model: one-cycle event pulses and the io refresh pulse
// assumes requests from the bench change just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module hsc_core_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_refresh_req,
   input  wire logic [3:0] i_ev_req,
   output logic            o_io_refresh,
   output logic [3:0]      o_ev
);
   // pulses last one cycle, as short edges from the pins would
   always_ff @(posedge i_sys_clk) begin
      o_io_refresh <= i_refresh_req;
      o_ev         <= i_ev_req;
   end
endmodule // hsc_core_model
`default_nettype wire

/* File: testbench/hsc_bank_bench.sv */
// self-checking bench for the counter status and general word map
// assumes the package offsets and a 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module hsc_bank_bench;
   import hsc_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rq = 0, lin = 0, sim = 0;
   logic up = 0, lo = 0, cup = 0, flt = 0, rfr;
   logic [8:0] addr = 0;
   logic [15:0] wd = 0, rdat, d;
   logic [3:0] evq = 0, ev;
   logic [1:0] rr = 0, drv, iim, dout;
   logic [31:0] cnt = 0, act = 0, p1 = 0, p2 = 0, oim, outs, hold;
   logic [7:0] cf, inf, ot, it;
   logic gate, cmp;
   int n_errors = 0, tests_run = 0;
   hsc_bank hsc_bank_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
      .i_io_refresh(rfr), .i_linear(lin), .i_simple(sim), .i_at_upper(up),
      .i_at_lower(lo), .i_count_up(cup), .i_count_value(cnt),
      .i_ev_preset(ev[0]), .i_ev_reset(ev[1]), .i_ev_capture(ev[2]),
      .i_ev_index(ev[3]), .i_rate_range(rr), .i_range_active(act),
      .i_pattern_c1(p1), .i_pattern_c2(p2), .i_fault(flt),
      .o_gate_open(gate), .o_compare_mode(cmp), .o_driver_source(drv),
      .o_cnt_filter(cf), .o_in_filter(inf), .o_otask_offset(ot),
      .o_itask_offset(it), .o_oirq_mask(oim), .o_iirq_mask(iim),
      .o_outputs(outs), .o_dout(dout));
   hsc_core_model hsc_core_model_inst (.i_sys_clk(clk), .i_refresh_req(rq),
      .i_ev_req(evq), .o_io_refresh(rfr), .o_ev(ev));
   initial forever #50 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_w(input logic [8:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1; addr <= a; wd <= v;
      @(posedge clk);
      wr <= 0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_w(input logic [8:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1; addr <= a;
      @(posedge clk);
      rd <= 0;
      @(negedge clk);
      v = rdat;
      @(posedge clk); // callers drive again from a rising edge
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
      rd_w(a, d);
      `CHK(d, e)
   endtask
   // status word model built from the core levels
   function automatic logic [15:0] stat(input logic g, input logic [3:0] e);
      // rate bits mean nothing for a simple counter
      return {sim, 3'b000, sim ? 2'b00 : rr, 2'b00, e, cup, g, lin & lo,
         lin & up};
   endfunction
   task automatic tally_and_finish;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // watchdog: the whole run needs about 45k cycles
   initial begin
      #(60_000 * 100);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h6142));
      cyc(20);
      rst_n <= 1;
      cyc(1);
      `CHK(gate, 1'b0)
      `CHK(cmp, 1'b0)
      rd_chk(OFS_CFILT, RST_WORD);
      for (int c = 0; c < 3; c++) begin
         wr_w(OFS_CFILT, 16'(c));
         cyc(1);
         `CHK(cf, 8'(c))
      end
      for (int c = 0; c < 2; c++) begin
         wr_w(OFS_IFILT, 16'(c));
         cyc(1);
         `CHK(inf, 8'(c))
      end
      wr_w(OFS_MODE, 16'h0001);
      cyc(1);
      `CHK(cmp, 1'b1)
      wr_w(OFS_DRV, 16'hFFFF);
      rd_chk(OFS_DRV, 16'hF003);
      `CHK(drv, 2'b11)
      wr_w(OFS_DRV, 16'h0002);
      cyc(1);
      `CHK(drv, 2'b10)
      hold = $urandom;
      wr_w(OFS_OMASK_LO, hold[15:0]);
      wr_w(OFS_OMASK_HI, hold[31:16]);
      wr_w(OFS_IMASK, 16'h0002);
      cyc(1);
      `CHK(oim, hold)
      `CHK(iim, 2'b10)
      wr_w(OFS_OTASK, OTASK_MAX);
      wr_w(OFS_OTASK, 16'h0193);
      rd_chk(OFS_OTASK, OTASK_MAX);
      `CHK(ot, 8'd192)
      wr_w(OFS_ITASK, ITASK_MAX);
      wr_w(OFS_ITASK, 16'h0253);
      rd_chk(OFS_ITASK, ITASK_MAX);
      `CHK(it, 8'd252)
      wr_w(9'h00D, 16'h0000); // reserved words only ever get zero
      rd_chk(9'h017, 16'h0000);
      rd_chk(9'h1B0, 16'h0000);
      // status words: open the gate, snapshot twice, then close it and snapshot again
      wr_w(OFS_CTRL, 16'h0001);
      cnt <= $urandom; act <= $urandom;
      lin <= 1; up <= 1; cup <= 1; rr <= 2'b01;
      evq <= 4'b1001;
      @(posedge clk);
      evq <= 0; rq <= 1;
      @(posedge clk);
      rq <= 0;
      cyc(2);
      `CHK(gate, 1'b1)
      rd_chk(OFS_STAT, stat(1'b1, 4'b1001));
      rd_chk(OFS_ACT_LO, act[15:0]);
      rd_chk(OFS_ACT_HI, act[31:16]);
      rd_chk(OFS_CNT_HI, cnt[31:16]);
      up <= 0; lo <= 1; cup <= 0; rr <= 2'b10; evq <= 4'b0110;
      rq <= 1;
      @(posedge clk);
      evq <= 0; rq <= 0;
      cyc(2);
      rd_chk(OFS_STAT, stat(1'b1, 4'b0110));
      wr_w(OFS_CTRL, 16'h0000);
      sim <= 1; rr <= 2'b11; rq <= 1;
      @(posedge clk);
      rq <= 0;
      cyc(2);
      rd_chk(OFS_STAT, stat(1'b0, 4'b0000));
      rd_chk(OFS_ACT_LO, 16'h0000);
      // output pattern combining and fault states
      p1 <= $urandom; p2 <= $urandom;
      wr_w(OFS_MODE, 16'h0100);
      cyc(3);
      `CHK(outs, p1 & p2)
      wr_w(OFS_MODE, 16'h0000);
      cyc(3);
      `CHK(outs, p1 | p2)
      hold = p1 | p2;
      wr_w(OFS_DRV, 16'h1000);
      flt <= 1; p1 <= ~p1;
      cyc(3);
      `CHK(outs, hold)
      wr_w(OFS_PAT_LO, 16'h5A3C);
      wr_w(OFS_PAT_HI, 16'hC3A5);
      wr_w(OFS_DRV, 16'h2000);
      cyc(3);
      `CHK(outs, 32'hC3A5_5A3C)
      wr_w(OFS_DRV, 16'h0000);
      cyc(3);
      `CHK(outs, p1 | p2)
      // pulse timers: 2 ms delay, 2 ms and endless duration
      flt <= 0; p1 <= 0; p2 <= 0;
      wr_w(OFS_DLY0, 16'h0002);
      wr_w(OFS_DUR0, 16'h0002);
      wr_w(OFS_DLY1, 16'h0002);
      wr_w(OFS_DUR1, 16'h0000);
      cyc(5);
      p1 <= 32'h0000_0003;
      cyc(9000);
      `CHK(dout, 2'b00)
      cyc(11500);
      `CHK(dout, 2'b11)
      cyc(24500);
      `CHK(dout, 2'b10)
      tally_and_finish;
   end
endmodule // hsc_bank_bench
`default_nettype wire
